// ==== inc/lcd_map.svh ====
// Purpose: constants of the lcd command/data link and host registers
// Assumes: pclk at 50 MHz
// Notes: Behaviour list below
//
// Behaviour
// - 01 prefix in normal table loads glyph address, targets glyph
// - top bit set loads char address, targets char
// - one-line char addresses run 00h to 4fh
// - two-line: 00h-27h then 40h-67h
// - three-line: blocks ending 0fh, 1fh, 2fh
// - status read returns busy and address counter
// - host never instructs while busy; device refuses
// - each data access steps address counter
// - data write stores to selected memory
// - data read returns selected memory byte
// - first unprimed read invalid; host discards it
// - bias instruction selects quarter or fifth bias
// - bias bit ignored with external resistors
// - host writes fix bit per three-line use
// - extension table loads symbol memory address
// - 0101 sets symbol display, booster, contrast high
// - booster only with internal follower straps
// - contrast six bits, internal follower only
// - 0110 sets follower and gain, internal only
// - host clears follower unless straps both low
// - three-line tall font row split by upper select
// - entry direction steps counter up or down
// - table select gates extension instruction decode
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH
`define LCD_CLK_NS     20
`define LCD_EXEC_NS    26300
`define LCD_EXEC_CYC   ((`LCD_EXEC_NS + `LCD_CLK_NS - 1) / `LCD_CLK_NS)
`define LCD_BUSY_W     11
`define LCD_SPACE_CODE 8'h20
`define LCD_TBL_NORM   2'b00
`define LCD_TBL_EXT1   2'b01
`define LCD_TBL_EXT2   2'b10
`define LCD_ONE_LAST   7'h4f
`define LCD_TWO_L1END  7'h27
`define LCD_TWO_L2BEG  7'h40
`define LCD_TWO_L2END  7'h67
`define LCD_TRI_LAST   7'h2f
`define LCD_ROW_FIRST  5'd1
`define LCD_ROW_MID    5'd9
`define LCD_ROW_16     5'd16
`define LCD_ROW_LAST   5'd24
`define HOST_CMD_OFS   12'h000
`define HOST_STAT_OFS  12'h004
`define HOST_CFG_OFS   12'h008
`define HOST_CMD_RS    8
`define HOST_CMD_RW    9
`endif

// ==== inc/lcd_pkg.sv ====
// Purpose: types shared by both ends of the lcd link
// Assumes: nothing
// Notes: state structs of each end
package lcd_pkg;
  typedef enum logic [1:0] {
    MEM_CHAR   = 2'b00,
    MEM_GLYPH  = 2'b01,
    MEM_SYMBOL = 2'b10
  } mem_sel_e;

  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_POLL   = 3'b001,
    H_POLL_W = 3'b010,
    H_SEND   = 3'b011,
    H_SEND_W = 3'b100
  } host_st_e;

  typedef struct packed {
    logic [6:0]  ac;
    mem_sel_e    target;
    logic        inc;
    logic        two_line;
    logic        tall;
    logic        upper_sel;
    logic [1:0]  table_sel;
    logic        bias_sel;
    logic        fix_bit;
    logic        icon_on;
    logic        booster_on;
    logic [5:0]  contrast;
    logic        follower_on;
    logic [2:0]  gain;
    logic [10:0] busy_cnt;
    logic        busy_flag;
    logic        refetch;
    logic [7:0]  rd_latch;
    logic        clr_on;
    logic [6:0]  clr_idx;
    logic        ack;
    logic [7:0]  rdata;
    logic        oe_n;
    logic        in_disp;
    logic [4:0]  dh_first;
    logic [4:0]  dh_last;
  } dev_s;

  typedef struct packed {
    host_st_e    st;
    logic [7:0]  cmd;
    logic        cmd_rs;
    logic        cmd_rw;
    logic        pending;
    logic        dummy;
    logic        primed;
    logic [1:0]  table_sel;
    logic [7:0]  last_rd;
    logic        rd_valid;
    logic [1:0]  cfg_strap;
    logic        cfg_tri;
    logic        req;
    logic        rs;
    logic        rw;
    logic [7:0]  wdata;
    logic [31:0] prdata;
    logic        pready;
  } host_s;
endpackage

// ==== inc/lcd_bus_if.sv ====
// Purpose: command/data link between host end and device end
// Assumes: single clock, req and ack are one-cycle pulses
// Notes: device drives read bytes with oe_n low
`timescale 1ns/100ps
`default_nettype none
interface lcd_bus_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic       req;
  logic       cmd_data_select;
  logic       rw;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       oe_n;

  modport host (
    input  pclk, presetn, ack, rdata, oe_n,
    output req, cmd_data_select, rw, wdata
  );
  modport dev (
    input  pclk, presetn, req, cmd_data_select, rw, wdata,
    output ack, rdata, oe_n
  );
endinterface
`default_nettype wire

// ==== verilog/lcd_dev_end.sv ====
// Purpose: instruction and data decoder of the character lcd controller
// Assumes: host waits for ack before the next request
// Notes: memories are plain arrays, no reset
`timescale 1ns/100ps
`default_nettype none
`include "lcd_map.svh"
module lcd_dev_end (
  // link
  lcd_bus_if.dev          bus,
  // straps
  input  wire logic [1:0] bias_source_strap,
  input  wire logic       triple_line_strap,
  // settings
  output logic            busy_flag,
  output logic [6:0]      address_counter,
  output logic            bias_ratio_select,
  output logic            three_line_fix_bit,
  output logic            icon_on,
  output logic            booster_on,
  output logic [5:0]      contrast_level,
  output logic            follower_on,
  output logic [2:0]      drive_gain_ratio,
  output logic [1:0]      table_page_select,
  output logic            two_line,
  output logic            tall_font_select,
  output logic            tall_font_upper_select,
  output logic            ac_in_display,
  output logic [4:0]      tall_row_first,
  output logic [4:0]      tall_row_last
);
  lcd_pkg::dev_s q;
  lcd_pkg::dev_s d;
  logic [7:0] char_mem [0:127];
  logic [7:0] glyph_mem [0:63];
  logic [7:0] symbol_mem [0:15];
  logic       mem_we;
  lcd_pkg::mem_sel_e mem_sel;
  logic [6:0] mem_addr;
  logic [7:0] mem_wd;
  logic [7:0] mem_at;
  logic [7:0] b;
  logic       internal;

  function automatic logic [6:0] step_ac(
    input logic [6:0]        a,
    input lcd_pkg::mem_sel_e t,
    input logic              up,
    input logic              two,
    input logic              three
  );
    logic [6:0] n;
    n = up ? a + 7'h01 : a - 7'h01;
    unique case (t)
      lcd_pkg::MEM_GLYPH:  step_ac = {1'b0, n[5:0]};
      lcd_pkg::MEM_SYMBOL: step_ac = {3'h0, n[3:0]};
      default: begin
        if (two && three) begin
          if (up) step_ac = (a >= `LCD_TRI_LAST) ? 7'h00 : n;
          else step_ac = (a == 7'h00) ? `LCD_TRI_LAST : n;
        end else if (two) begin
          if (up && a == `LCD_TWO_L1END) step_ac = `LCD_TWO_L2BEG;
          else if (up && a >= `LCD_TWO_L2END) step_ac = 7'h00;
          else if (!up && a == `LCD_TWO_L2BEG) step_ac = `LCD_TWO_L1END;
          else if (!up && a == 7'h00) step_ac = `LCD_TWO_L2END;
          else step_ac = n;
        end else begin
          if (up) step_ac = (a >= `LCD_ONE_LAST) ? 7'h00 : n;
          else step_ac = (a == 7'h00) ? `LCD_ONE_LAST : n;
        end
      end
    endcase
  endfunction

  function automatic logic in_display(
    input logic [6:0] a,
    input logic       two,
    input logic       three
  );
    if (two && three) in_display = (a <= `LCD_TRI_LAST);
    else if (two) in_display = (a <= `LCD_TWO_L1END) ||
      (a >= `LCD_TWO_L2BEG && a <= `LCD_TWO_L2END);
    else in_display = (a <= `LCD_ONE_LAST);
  endfunction

  always_comb begin
    unique case (q.target)
      lcd_pkg::MEM_GLYPH:  mem_at = glyph_mem[q.ac[5:0]];
      lcd_pkg::MEM_SYMBOL: mem_at = symbol_mem[q.ac[3:0]];
      default:             mem_at = char_mem[q.ac];
    endcase
  end

  always_comb begin
    d = q;
    b = bus.wdata;
    internal = (bias_source_strap == 2'b00);
    mem_we = 1'b0;
    mem_sel = q.target;
    mem_addr = q.ac;
    mem_wd = b;
    d.ack = 1'b0;
    d.oe_n = 1'b1;
    if (q.busy_cnt != '0) begin
      d.busy_cnt = q.busy_cnt - 11'd1;
      if (q.clr_on) begin
        mem_we = 1'b1;
        mem_sel = lcd_pkg::MEM_CHAR;
        mem_addr = q.clr_idx;
        mem_wd = `LCD_SPACE_CODE;
        d.clr_idx = q.clr_idx + 7'h01;
        if (q.clr_idx == 7'h7f) d.clr_on = 1'b0;
      end
      if (q.busy_cnt == 11'd1 && q.refetch) begin
        d.rd_latch = mem_at;
        d.refetch = 1'b0;
      end
    end
    if (bus.req) begin
      d.ack = 1'b1;
      d.rdata = 8'h00;
      if (!bus.cmd_data_select && bus.rw) begin
        d.rdata = {q.busy_flag, q.ac};
        d.oe_n = 1'b0;
      end else if (q.busy_flag) begin
        d.rdata = 8'h00;
      end else if (bus.cmd_data_select && bus.rw) begin
        d.rdata = q.rd_latch;
        d.oe_n = 1'b0;
        d.ac = step_ac(q.ac, q.target, q.inc, q.two_line,
                       triple_line_strap);
        d.refetch = 1'b1;
        d.busy_cnt = `LCD_BUSY_W'(`LCD_EXEC_CYC);
      end else if (bus.cmd_data_select) begin
        mem_we = 1'b1;
        d.ac = step_ac(q.ac, q.target, q.inc, q.two_line,
                       triple_line_strap);
        d.busy_cnt = `LCD_BUSY_W'(`LCD_EXEC_CYC);
      end else begin
        d.busy_cnt = `LCD_BUSY_W'(`LCD_EXEC_CYC);
        if (b[7]) begin
          d.ac = b[6:0];
          d.target = lcd_pkg::MEM_CHAR;
          d.refetch = 1'b1;
        end else if (q.table_sel == `LCD_TBL_NORM && b[7:6] == 2'b01) begin
          d.ac = {1'b0, b[5:0]};
          d.target = lcd_pkg::MEM_GLYPH;
          d.refetch = 1'b1;
        end else if (b[7:5] == 3'b001) begin
          d.two_line = b[3];
          d.tall = b[2];
          d.table_sel = b[1:0];
        end else if (q.table_sel == `LCD_TBL_EXT1) begin
          unique case (b[7:4])
            4'b0100: begin
              d.ac = {3'h0, b[3:0]};
              d.target = lcd_pkg::MEM_SYMBOL;
              d.refetch = 1'b1;
            end
            4'b0101: begin
              d.icon_on = b[3];
              if (internal) begin
                d.booster_on = b[2];
                d.contrast[5:4] = b[1:0];
              end
            end
            4'b0110: begin
              if (internal) begin
                d.follower_on = b[3];
                d.gain = b[2:0];
              end
            end
            4'b0111: begin
              if (internal) d.contrast[3:0] = b[3:0];
            end
            4'b0001: begin
              if (b[2:1] == 2'b10) begin
                if (bias_source_strap != 2'b11) d.bias_sel = b[3];
                d.fix_bit = b[0];
              end
            end
            default: d.busy_cnt = `LCD_BUSY_W'(`LCD_EXEC_CYC);
          endcase
        end else if (q.table_sel == `LCD_TBL_EXT2) begin
          if (b[7:4] == 4'b0001) d.upper_sel = b[3];
        end else if (q.table_sel == `LCD_TBL_NORM) begin
          if (b[7:2] == 6'b000001) d.inc = b[1];
          else if (b[7:1] == 7'b0000001) begin
            d.ac = 7'h00;
            d.target = lcd_pkg::MEM_CHAR;
            d.refetch = 1'b1;
          end else if (b == 8'h01) begin
            d.ac = 7'h00;
            d.inc = 1'b1;
            d.target = lcd_pkg::MEM_CHAR;
            d.clr_on = 1'b1;
            d.clr_idx = 7'h00;
            d.refetch = 1'b1;
          end
        end
      end
    end
    d.busy_flag = (d.busy_cnt != '0);
    d.in_disp = in_display(d.ac, d.two_line, triple_line_strap);
    d.dh_first = 5'd0;
    d.dh_last = 5'd0;
    if (triple_line_strap && d.two_line && d.tall) begin
      d.dh_first = d.upper_sel ? `LCD_ROW_FIRST : `LCD_ROW_MID;
      d.dh_last = d.upper_sel ? `LCD_ROW_16 : `LCD_ROW_LAST;
    end
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      q <= '0;
      q.inc <= 1'b1;
      q.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge bus.pclk) begin
    if (mem_we) begin
      unique case (mem_sel)
        lcd_pkg::MEM_GLYPH:  glyph_mem[mem_addr[5:0]] <= mem_wd;
        lcd_pkg::MEM_SYMBOL: symbol_mem[mem_addr[3:0]] <= mem_wd;
        default:             char_mem[mem_addr] <= mem_wd;
      endcase
    end
  end

  assign bus.ack = q.ack;
  assign bus.rdata = q.rdata;
  assign bus.oe_n = q.oe_n;
  assign busy_flag = q.busy_flag;
  assign address_counter = q.ac;
  assign bias_ratio_select = q.bias_sel;
  assign three_line_fix_bit = q.fix_bit;
  assign icon_on = q.icon_on;
  assign booster_on = q.booster_on;
  assign contrast_level = q.contrast;
  assign follower_on = q.follower_on;
  assign drive_gain_ratio = q.gain;
  assign table_page_select = q.table_sel;
  assign two_line = q.two_line;
  assign tall_font_select = q.tall;
  assign tall_font_upper_select = q.upper_sel;
  assign ac_in_display = q.in_disp;
  assign tall_row_first = q.dh_first;
  assign tall_row_last = q.dh_last;
endmodule
`default_nettype wire

// ==== verilog/lcd_host_end.sv ====
// Purpose: apb-driven host end issuing lcd instructions and data
// Assumes: device end answers every req with one ack
// Notes: polls busy before each transfer except a status read
`timescale 1ns/100ps
`default_nettype none
`include "lcd_map.svh"
module lcd_host_end (
  // link
  lcd_bus_if.host          bus,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  lcd_pkg::host_s q;
  lcd_pkg::host_s d;
  logic [7:0] fixed;
  logic       wr_acc;

  always_comb begin
    d = q;
    d.req = 1'b0;
    d.pready = psel && !penable;
    wr_acc = psel && penable && q.pready && pwrite;
    fixed = q.cmd;
    if (!q.cmd_rs && !q.cmd_rw && q.table_sel == `LCD_TBL_EXT1) begin
      if (q.cmd[7:4] == 4'b0001 && q.cmd[2:1] == 2'b10)
        fixed[0] = q.cfg_tri;
      if (q.cmd[7:4] == 4'b0110 && q.cfg_strap != 2'b00)
        fixed[3] = 1'b0;
    end
    if (psel && !penable) begin
      unique case (paddr)
        `HOST_CMD_OFS:  d.prdata = {22'h0, q.cmd_rw, q.cmd_rs, q.cmd};
        `HOST_STAT_OFS: d.prdata = {15'h0, q.rd_valid, q.last_rd,
                                    7'h0, q.pending};
        `HOST_CFG_OFS:  d.prdata = {29'h0, q.cfg_tri, q.cfg_strap};
        default:        d.prdata = 32'h0;
      endcase
    end
    if (wr_acc && paddr == `HOST_CFG_OFS) begin
      d.cfg_strap = pwdata[1:0];
      d.cfg_tri = pwdata[2];
    end
    unique case (q.st)
      lcd_pkg::H_IDLE: begin
        if (wr_acc && paddr == `HOST_CMD_OFS) begin
          d.cmd = pwdata[7:0];
          d.cmd_rs = pwdata[`HOST_CMD_RS];
          d.cmd_rw = pwdata[`HOST_CMD_RW];
          d.pending = 1'b1;
          d.rd_valid = 1'b0;
          d.dummy = pwdata[`HOST_CMD_RS] && pwdata[`HOST_CMD_RW] &&
                    !q.primed;
          if (!pwdata[`HOST_CMD_RS] && pwdata[`HOST_CMD_RW])
            d.st = lcd_pkg::H_SEND;
          else
            d.st = lcd_pkg::H_POLL;
        end
      end
      lcd_pkg::H_POLL: begin
        d.req = 1'b1;
        d.rs = 1'b0;
        d.rw = 1'b1;
        d.wdata = 8'h00;
        d.st = lcd_pkg::H_POLL_W;
      end
      lcd_pkg::H_POLL_W: begin
        if (bus.ack)
          d.st = bus.rdata[7] ? lcd_pkg::H_POLL : lcd_pkg::H_SEND;
      end
      lcd_pkg::H_SEND: begin
        d.req = 1'b1;
        d.rs = q.cmd_rs;
        d.rw = q.cmd_rw;
        d.wdata = fixed;
        d.st = lcd_pkg::H_SEND_W;
      end
      lcd_pkg::H_SEND_W: begin
        if (bus.ack) begin
          if (q.dummy) begin
            d.dummy = 1'b0;
            d.st = lcd_pkg::H_POLL;
          end else begin
            d.st = lcd_pkg::H_IDLE;
            d.pending = 1'b0;
            if (q.cmd_rw) begin
              d.last_rd = bus.rdata;
              d.rd_valid = 1'b1;
            end
            if (q.cmd_rs) d.primed = q.cmd_rw;
            else if (!q.cmd_rw) begin
              if (q.cmd[7] || (q.cmd[7:6] == 2'b01 &&
                  q.table_sel == `LCD_TBL_NORM) ||
                  (q.cmd[7:4] == 4'b0100 &&
                  q.table_sel == `LCD_TBL_EXT1))
                d.primed = 1'b1;
              if (q.cmd[7:5] == 3'b001) d.table_sel = q.cmd[1:0];
            end
          end
        end
      end
      default: d.st = lcd_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.req = q.req;
  assign bus.cmd_data_select = q.rs;
  assign bus.rw = q.rw;
  assign bus.wdata = q.wdata;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = 1'b0;
endmodule
`default_nettype wire

// ==== bench/lcd_link_monitor.sv ====
// Purpose: link checks between host end and device end
// Assumes: busy lasts 1315 cycles after an accepted op
// Notes: sees the link signals only
`timescale 1ns/100ps
`default_nettype none
module lcd_link_monitor (
  // clock, reset
  input wire logic       pclk,
  input wire logic       presetn,
  // link
  input wire logic       req,
  input wire logic       cmd_data_select,
  input wire logic       rw,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       oe_n
);
  logic [10:0] since_q;
  logic [10:0] since_d;
  logic        stat;
  logic        op;
  assign stat = req && !cmd_data_select && rw;
  assign op = req && !stat;
  always_comb begin
    since_d = since_q;
    if (op) begin
      since_d = 11'h000;
    end else if (since_q != 11'h7ff) begin
      since_d = since_q + 11'h001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= 11'h7ff;
    end else begin
      since_q <= since_d;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ack_one_cycle_a: assert property (req |=> ack ##1 !ack)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  status_drive_a: assert property (stat |=> !oe_n)
    else $error("status read not driven");
  read_drive_a: assert property (op && rw |=> !oe_n)
    else $error("data read not driven");
  write_release_a: assert property (req && !rw |=> oe_n)
    else $error("bus driven on write");
  drive_in_ack_a: assert property (!oe_n |-> ack)
    else $error("bus driven outside ack");
  rdata_hold_a: assert property (!ack |-> $stable(rdata))
    else $error("read byte moved outside ack");
  host_wait_a: assert property (op |-> since_q > 11'd1315)
    else $error("request sent while busy");
  busy_read_a: assert property (
    stat && since_q >= 11'd2 && since_q <= 11'd1300 |=> rdata[7])
    else $error("busy not seen during execution");
  idle_read_a: assert property (
    stat && since_q >= 11'd1330 |=> !rdata[7])
    else $error("busy seen after execution");
  cover property (stat ##1 ack);
  cover property (op && rw);
  cover property (op && !cmd_data_select && wdata[7]);
endmodule
`default_nettype wire

// ==== bench/char_lcd_instruction_decoder_test.sv ====
// Purpose: bench for both lcd link ends
// Assumes: busy 1315 cycles at 50 MHz
// Notes: second link driven by the bench as host
`timescale 1ns/100ps
`default_nettype none
`include "lcd_map.svh"
module char_lcd_instruction_decoder_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic [1:0]  strap;
  logic        tri_s;
  logic        bsy;
  logic        bsy_b;
  logic        two_b;
  logic [6:0]  ac;
  logic        bias;
  logic        fix;
  logic        icon;
  logic        boost;
  logic [5:0]  contr;
  logic        foll;
  logic [2:0]  gain;
  logic [1:0]  tbl;
  logic        two;
  logic [4:0]  rf;
  logic [4:0]  rl;
  logic        tall;
  logic        ups;
  logic        ind;
  logic [31:0] st;
  logic [7:0]  q8;
  logic [7:0]  d;
  logic [6:0]  a;
  int          n_fail;
  int          n_checks;
  int          seed;
  int          n;
  lcd_bus_if bus_a (.pclk(pclk), .presetn(presetn));
  lcd_bus_if bus_b (.pclk(pclk), .presetn(presetn));
  lcd_host_end u_lcd_host_end (.bus(bus_a), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr());
  lcd_dev_end u_lcd_dev_end (.bus(bus_a), .bias_source_strap(strap),
    .triple_line_strap(tri_s), .busy_flag(bsy), .address_counter(ac),
    .bias_ratio_select(bias), .three_line_fix_bit(fix), .icon_on(icon),
    .booster_on(boost), .contrast_level(contr), .follower_on(foll),
    .drive_gain_ratio(gain), .table_page_select(tbl), .two_line(two),
    .tall_font_select(tall), .tall_font_upper_select(ups),
    .ac_in_display(ind), .tall_row_first(rf), .tall_row_last(rl));
  lcd_dev_end u_lcd_dev_end_b (.bus(bus_b), .bias_source_strap(strap),
    .triple_line_strap(1'b0), .busy_flag(bsy_b), .address_counter(),
    .bias_ratio_select(), .three_line_fix_bit(), .icon_on(),
    .booster_on(), .contrast_level(), .follower_on(),
    .drive_gain_ratio(), .table_page_select(), .two_line(two_b),
    .tall_font_select(), .tall_font_upper_select(), .ac_in_display(),
    .tall_row_first(), .tall_row_last());
  lcd_link_monitor u_lcd_link_monitor (.pclk(pclk), .presetn(presetn),
    .req(bus_a.req), .cmd_data_select(bus_a.cmd_data_select),
    .rw(bus_a.rw), .wdata(bus_a.wdata), .ack(bus_a.ack),
    .rdata(bus_a.rdata), .oe_n(bus_a.oe_n));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  function automatic logic [6:0] step(input logic [6:0] x, input int m);
    logic [6:0] t;
    begin
      t = x + 7'h01;
      case (m)
        0: t = (x == 7'h4f) ? 7'h00 : t;
        1: t = (x == 7'h27) ? 7'h40 : t;
        2: t = (x == 7'h2f) ? 7'h00 : t;
        3: t = t & 7'h3f;
        4: t = (x - 7'h01) & 7'h3f;
        default: t = t & 7'h0f;
      endcase
      return t;
    end
  endfunction
  task automatic results;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  task automatic bail;
    begin
      n_fail++;
      results();
    end
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    begin
      n_checks++;
      if (s !== e) begin
        n_fail++;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] wd, output logic [31:0] rd);
    int k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
        bail();
      end
    end
  endtask
  task automatic send(input logic [9:0] cmd);
    int k;
    begin
      apb(1'b1, `HOST_CMD_OFS, {22'h0, cmd}, st);
      k = 0;
      do begin
        apb(1'b0, `HOST_STAT_OFS, 32'h0, st);
        k++;
      end while (st[0] !== 1'b0 && k < 2000);
      if (k >= 2000) begin
        bail();
      end
    end
  endtask
  task automatic link(input logic rs, input logic r, input logic [7:0] wd,
                      output logic [7:0] rd);
    int k;
    begin
      @(posedge pclk);
      bus_b.req <= 1'b1;
      bus_b.cmd_data_select <= rs;
      bus_b.rw <= r;
      bus_b.wdata <= wd;
      @(posedge pclk);
      bus_b.req <= 1'b0;
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (bus_b.ack !== 1'b1 && k < 4);
      rd = bus_b.rdata;
      bus_b.wdata <= ~wd;
      if (k >= 4) begin
        bail();
      end
    end
  endtask
  task automatic idle;
    int k;
    begin
      k = 0;
      while ((bsy !== 1'b0 || bsy_b !== 1'b0) && k < 2000) begin
        @(posedge pclk);
        k++;
      end
      if (k >= 2000) begin
        bail();
      end
    end
  endtask
  initial begin
    seed = 32'hb72d7da7;
    n_fail = 0;
    n_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {strap, tri_s} = 3'h0;
    {bus_b.req, bus_b.cmd_data_select, bus_b.rw, bus_b.wdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h00c, 32'h0, st);
    chk(st, 32'h0);
    apb(1'b1, `HOST_CFG_OFS, 32'h0, st);
    send(10'h038);
    chk(32'(two), 32'h1);
    send(10'h004);
    send(10'h001);
    send(10'h0a7);
    chk(32'(ac), 32'h27);
    chk(32'(ind), 32'h1);
    d = 8'($random(seed));
    send({2'b01, d});
    chk(32'(ac), 32'(step(7'h27, 1)));
    send(10'h07f);
    chk(32'(ac), 32'h3f);
    chk(32'(ind), 32'h0);
    send({2'b01, d});
    chk(32'(ac), 32'(step(7'h3f, 3)));
    send(10'h07f);
    send(10'h300);
    chk(32'(st[16:8]), 32'({1'b1, d}));
    send(10'h085);
    send(10'h111);
    d = 8'($random(seed));
    send({2'b01, d});
    send(10'h004);
    send(10'h300);
    chk(32'({st[15:8], ac}), 32'({d, 7'h05}));
    send(10'h040);
    send(10'h1c3);
    chk(32'(ac), 32'(step(7'h00, 4)));
    send(10'h006);
    send(10'h030);
    send(10'h0cf);
    send(10'h155);
    chk(32'({two, ac}), 32'(step(7'h4f, 0)));
    idle();
    send(10'h200);
    chk(32'(st[15:8]), 32'({1'b0, step(7'h4f, 0)}));
    send(10'h039);
    send(10'h01c);
    chk(32'({tbl, bias, fix}), 32'h6);
    a = 7'($random(seed));
    send({6'h05, 2'b11, a[1:0]}); // icon, booster, contrast high
    send({6'h07, a[5:2]});
    send({6'h06, 1'b1, 3'h5});
    chk(32'({icon, boost, contr}), 32'({2'b11, a[1:0], a[5:2]}));
    chk(32'({foll, gain}), 32'h0d);
    send({6'h04, a[3:0]});
    chk(32'(ac), 32'(a[3:0]));
    send(10'h1e1);
    chk(32'(ac), 32'(step(7'(a[3:0]), 5)));
    strap <= 2'b11;
    apb(1'b1, `HOST_CFG_OFS, 32'h7, st);
    send(10'h014);
    chk(32'({fix, bias}), 32'h3);
    send(10'h050);
    chk(32'({icon, boost, contr}), 32'({2'b01, a[1:0], a[5:2]}));
    send(10'h06a);
    chk(32'({foll, gain}), 32'h0d);
    send(10'h038);
    send(10'h05c);
    chk(32'({tbl, ac}), 32'h1c);
    strap <= 2'b00;
    tri_s <= 1'b1;
    apb(1'b1, `HOST_CFG_OFS, 32'h4, st);
    send(10'h03c);
    send(10'h0af);
    send(10'h1aa);
    chk(32'(ac), 32'(step(7'h2f, 2)));
    send(10'h03e);
    send(10'h018);
    chk(32'({tall, ups, rf, rl}), 32'({2'b11, 5'd1, 5'd16}));
    send(10'h010);
    chk(32'({tall, ups, rf, rl}), 32'({2'b10, 5'd9, 5'd24}));
    a = 7'($random(seed));
    link(1'b0, 1'b0, {1'b1, a}, q8);
    link(1'b0, 1'b0, 8'h38, q8);
    chk(32'(q8), 32'h0);
    link(1'b0, 1'b1, 8'h00, q8);
    chk(32'(q8), 32'({1'b1, a}));
    idle();
    chk(32'(two_b), 32'h0);
    link(1'b0, 1'b0, 8'h38, q8);
    n = 0;
    while (bsy_b === 1'b1 && n < 1400) begin
      n++;
      @(posedge pclk);
    end
    chk(32'(n), 32'(`LCD_EXEC_CYC));
    chk(32'(two_b), 32'h1);
    link(1'b0, 1'b1, 8'h00, q8);
    chk(32'(q8), 32'({1'b0, a}));
    results();
  end
endmodule
`default_nettype wire
